// ### rtl/alf_params.svh
`ifndef ALF_PARAMS_SVH
`define ALF_PARAMS_SVH

// Register byte offsets
`define ALF_OFF_CONTROL 8'h00
`define ALF_OFF_TBL_CTRL 8'h04
`define ALF_OFF_WORD0 8'h08
`define ALF_OFF_WORD1 8'h0C
`define ALF_OFF_WORD2 8'h10
`define ALF_OFF_STATUS 8'h14

// Control register bits
`define ALF_CTL_ENABLE 0
`define ALF_CTL_BYPASS 1
`define ALF_CTL_OUI_DENY 2

// Table access control fields
`define ALF_TC_IDX_HI 9
`define ALF_TC_WRITE 31

// Status register bits
`define ALF_ST_BUSY 0
`define ALF_ST_CMD_PEND 1
`define ALF_ST_TABLE_INIT 2

// Table geometry and entry layout
`define ALF_ENTRIES 1024
`define ALF_LAST_IDX 10'h3FF
`define ALF_TYPE_HI 61
`define ALF_TYPE_LO 60
`define ALF_VLAN_HI 59
`define ALF_VLAN_LO 48
`define ALF_GROUP_BIT 40
`define ALF_MASK_HI 68
`define ALF_MASK_LO 66
`define ALF_PORT_HI 67
`define ALF_PORT_LO 66
`define ALF_SUPER 65
`define ALF_BLOCK 65
`define ALF_SECURE 64
`define ALF_UTYPE_HI 63
`define ALF_UTYPE_LO 62

// Entry type and unicast type codes
`define ALF_TYPE_FREE 2'h0
`define ALF_TYPE_ADDR 2'h1
`define ALF_TYPE_VLAN 2'h2
`define ALF_TYPE_VADDR 2'h3
`define ALF_UTYPE_OUI 2'h2
`define ALF_UTYPE_LEARNED 2'h3

// Port masks
`define ALF_HOST_MASK 3'h1
`define ALF_MAC_MASK 3'h6
`define ALF_ALL_MASK 3'h7

`endif

// ### rtl/alf_pkg.sv
`include "alf_params.svh"

package alf_pkg;

	typedef enum logic [2:0] {alf_clear, alf_idle, alf_scan, alf_decide, alf_learn} alf_fsm_t;

	typedef struct packed {
		logic [1:0] rx_port;
		logic [47:0] dst;
		logic [47:0] src;
		logic [15:0] len_type;
		logic [11:0] vlan;
		logic err;
		logic ctl;
		logic abort;
		logic directed;
		logic [2:0] dir_mask;
	} alf_pkt_t;

	typedef struct packed {
		logic valid;
		logic [2:0] mask;
	} alf_res_t;

	typedef struct packed {
		alf_fsm_t fsm;
		logic ctl_en;
		logic ctl_bypass;
		logic ctl_oui;
		logic cmd_pend;
		logic cmd_wr;
		logic [9:0] cmd_idx;
		logic [71:0] words;
		logic wr_pend;
		logic [7:0] waddr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic pkt_ready;
		alf_pkt_t pkt;
		logic [9:0] idx;
		logic dst_hit;
		logic [71:0] dst_ent;
		logic src_hit;
		logic [9:0] src_idx;
		logic [71:0] src_ent;
		logic free_hit;
		logic [9:0] free_idx;
		logic oui_hit;
		alf_res_t res;
	} alf_state_t;

endpackage : alf_pkg

// ### rtl/alf_lookup.sv
`timescale 1ns/100ps
`include "alf_params.svh"

module alf_lookup
	import alf_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Packet request from receive paths
	input wire logic pkt_valid,
	input wire alf_pkt_t pkt,
	output logic pkt_ready,
	// Result to switch fabric
	output alf_res_t res
);

	alf_state_t st_reg;
	alf_state_t st_next;
	logic [71:0] tbl [0:`ALF_ENTRIES-1];
	logic tbl_we;
	logic [9:0] tbl_waddr;
	logic [71:0] tbl_wdata;
	logic [71:0] ent;
	logic [71:0] cmd_ent;
	logic resp_reg;

	function automatic logic [31:0] rd_mux(input logic [7:0] a, input alf_state_t s);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			`ALF_OFF_CONTROL:
			begin
				v[`ALF_CTL_ENABLE] = s.ctl_en;
				v[`ALF_CTL_BYPASS] = s.ctl_bypass;
				v[`ALF_CTL_OUI_DENY] = s.ctl_oui;
			end
			`ALF_OFF_TBL_CTRL:
			begin
				v[`ALF_TC_IDX_HI:0] = s.cmd_idx;
				v[`ALF_TC_WRITE] = s.cmd_wr;
			end
			`ALF_OFF_WORD0: v = s.words[31:0];
			`ALF_OFF_WORD1: v = s.words[63:32];
			`ALF_OFF_WORD2: v[7:0] = s.words[71:64];
			`ALF_OFF_STATUS:
			begin
				v[`ALF_ST_BUSY] = (s.fsm != alf_idle);
				v[`ALF_ST_CMD_PEND] = s.cmd_pend;
				v[`ALF_ST_TABLE_INIT] = (s.fsm == alf_clear);
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : rd_mux

	assign ent = tbl[st_reg.idx];
	assign cmd_ent = tbl[st_reg.cmd_idx];

	always_comb
	begin
		logic addr_ent;
		logic is_oui;
		logic dst_mc;
		logic super_pkt;
		logic [2:0] rx_bit;
		logic [2:0] others;
		logic [2:0] m;
		logic learn;
		logic [71:0] lw;
		addr_ent = 1'b0;
		is_oui = 1'b0;
		dst_mc = 1'b0;
		super_pkt = 1'b0;
		rx_bit = 3'h0;
		others = 3'h0;
		m = 3'h0;
		learn = 1'b0;
		lw = 72'h00_0000_0000_0000_0000;
		st_next = st_reg;
		tbl_we = 1'b0;
		tbl_waddr = 10'h000;
		tbl_wdata = 72'h00_0000_0000_0000_0000;
		st_next.res.valid = 1'b0;
		st_next.hreadyout = 1'b1;
		case (st_reg.fsm)
			alf_clear:
			begin
				tbl_we = 1'b1;
				tbl_waddr = st_reg.idx;
				st_next.idx = st_reg.idx + 10'h001;
				if (st_reg.idx == `ALF_LAST_IDX)
				begin
					st_next.idx = 10'h000;
					st_next.fsm = alf_idle;
				end
			end
			alf_idle:
			begin
				if (st_reg.cmd_pend)
				begin
					st_next.cmd_pend = 1'b0;
					if (st_reg.cmd_wr)
					begin
						tbl_we = 1'b1;
						tbl_waddr = st_reg.cmd_idx;
						tbl_wdata = st_reg.words;
					end
					else
						st_next.words = cmd_ent;
				end
				else if (pkt_valid && st_reg.pkt_ready)
				begin
					st_next.pkt = pkt;
					st_next.pkt.src[`ALF_GROUP_BIT] = 1'b0;
					st_next.idx = 10'h000;
					st_next.dst_hit = 1'b0;
					st_next.src_hit = 1'b0;
					st_next.free_hit = 1'b0;
					st_next.oui_hit = 1'b0;
					if (!st_reg.ctl_en || (pkt.directed && pkt.rx_port == 2'h0))
						st_next.fsm = alf_decide;
					else
						st_next.fsm = alf_scan;
				end
			end
			alf_scan:
			begin
				addr_ent = (ent[`ALF_TYPE_HI:`ALF_TYPE_LO] == `ALF_TYPE_ADDR) ||
					(ent[`ALF_TYPE_HI:`ALF_TYPE_LO] == `ALF_TYPE_VADDR &&
					ent[`ALF_VLAN_HI:`ALF_VLAN_LO] == st_reg.pkt.vlan);
				is_oui = ent[`ALF_TYPE_HI:`ALF_TYPE_LO] == `ALF_TYPE_ADDR &&
					ent[`ALF_UTYPE_HI:`ALF_UTYPE_LO] == `ALF_UTYPE_OUI;
				if (addr_ent && !is_oui && !st_reg.dst_hit && ent[47:0] == st_reg.pkt.dst)
				begin
					st_next.dst_hit = 1'b1;
					st_next.dst_ent = ent;
				end
				if (addr_ent && !is_oui && !st_reg.src_hit && ent[47:0] == st_reg.pkt.src)
				begin
					st_next.src_hit = 1'b1;
					st_next.src_idx = st_reg.idx;
					st_next.src_ent = ent;
				end
				if (is_oui && ent[47:24] == st_reg.pkt.src[47:24])
					st_next.oui_hit = 1'b1;
				if (!st_reg.free_hit && ent[`ALF_TYPE_HI:`ALF_TYPE_LO] == `ALF_TYPE_FREE)
				begin
					st_next.free_hit = 1'b1;
					st_next.free_idx = st_reg.idx;
				end
				st_next.idx = st_reg.idx + 10'h001;
				if (st_reg.idx == `ALF_LAST_IDX)
					st_next.fsm = alf_decide;
			end
			alf_decide:
			begin
				rx_bit = 3'h1 << st_reg.pkt.rx_port;
				others = `ALF_ALL_MASK & ~rx_bit;
				dst_mc = st_reg.pkt.dst[`ALF_GROUP_BIT];
				super_pkt = st_reg.dst_hit && (dst_mc ? st_reg.dst_ent[`ALF_SUPER] :
					(st_reg.dst_ent[`ALF_BLOCK] && st_reg.dst_ent[`ALF_SECURE]));
				if (!st_reg.ctl_en)
					m = 3'h0;
				else if (st_reg.pkt.directed && st_reg.pkt.rx_port == 2'h0)
					m = st_reg.pkt.dir_mask & `ALF_MAC_MASK;
				else if (st_reg.pkt.err || st_reg.pkt.ctl)
					m = st_reg.pkt.abort ? 3'h0 : `ALF_HOST_MASK;
				else if (st_reg.ctl_bypass && st_reg.pkt.rx_port != 2'h0)
					m = `ALF_HOST_MASK;
				else if (st_reg.pkt.src == st_reg.pkt.dst)
					m = 3'h0;
				else if (st_reg.ctl_oui && !super_pkt && !st_reg.oui_hit)
					m = 3'h0;
				else if (st_reg.dst_hit && dst_mc)
					m = st_reg.dst_ent[`ALF_MASK_HI:`ALF_MASK_LO] & others;
				else if (st_reg.dst_hit)
					m = (3'h1 << st_reg.dst_ent[`ALF_PORT_HI:`ALF_PORT_LO]) & others;
				else
					m = others;
				learn = st_reg.ctl_en && !(st_reg.pkt.directed && st_reg.pkt.rx_port == 2'h0) &&
					!st_reg.pkt.err && !st_reg.pkt.ctl &&
					(st_reg.src_hit || st_reg.free_hit);
				st_next.res.valid = 1'b1;
				st_next.res.mask = m;
				st_next.fsm = learn ? alf_learn : alf_idle;
			end
			alf_learn:
			begin
				if (st_reg.src_hit)
				begin
					lw = st_reg.src_ent;
					lw[`ALF_PORT_HI:`ALF_PORT_LO] = st_reg.pkt.rx_port;
				end
				else
				begin
					lw[`ALF_TYPE_HI:`ALF_TYPE_LO] = `ALF_TYPE_ADDR;
					lw[`ALF_UTYPE_HI:`ALF_UTYPE_LO] = `ALF_UTYPE_LEARNED;
					lw[`ALF_PORT_HI:`ALF_PORT_LO] = st_reg.pkt.rx_port;
					lw[47:0] = st_reg.pkt.src;
				end
				tbl_we = 1'b1;
				tbl_waddr = st_reg.src_hit ? st_reg.src_idx : st_reg.free_idx;
				tbl_wdata = lw;
				st_next.fsm = alf_idle;
			end
			default: st_next.fsm = alf_idle;
		endcase
		// Bus data phase after the engine, so a new command beats a clear
		if (st_reg.wr_pend)
		begin
			case (st_reg.waddr)
				`ALF_OFF_CONTROL:
				begin
					st_next.ctl_en = hwdata[`ALF_CTL_ENABLE];
					st_next.ctl_bypass = hwdata[`ALF_CTL_BYPASS];
					st_next.ctl_oui = hwdata[`ALF_CTL_OUI_DENY];
				end
				`ALF_OFF_TBL_CTRL:
				begin
					st_next.cmd_idx = hwdata[`ALF_TC_IDX_HI:0];
					st_next.cmd_wr = hwdata[`ALF_TC_WRITE];
					st_next.cmd_pend = 1'b1;
				end
				`ALF_OFF_WORD0: st_next.words[31:0] = hwdata;
				`ALF_OFF_WORD1: st_next.words[63:32] = hwdata;
				`ALF_OFF_WORD2: st_next.words[71:64] = hwdata[7:0];
				default: st_next.wr_pend = 1'b0;
			endcase
		end
		st_next.wr_pend = 1'b0;
		st_next.hrdata = 32'h0000_0000;
		if (hsel && htrans[1] && hready && hsize == 3'h2)
		begin
			st_next.wr_pend = hwrite;
			st_next.waddr = haddr[7:0];
			if (!hwrite)
				st_next.hrdata = rd_mux(haddr[7:0], st_next);
		end
		st_next.pkt_ready = (st_next.fsm == alf_idle) && !st_next.cmd_pend;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg <= '0;
			st_reg.fsm <= alf_clear;
			st_reg.hreadyout <= 1'b1;
			resp_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			resp_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (tbl_we)
			tbl[tbl_waddr] <= tbl_wdata;
	end

	assign hreadyout = st_reg.hreadyout;
	assign hresp = resp_reg;
	assign hrdata = st_reg.hrdata;
	assign pkt_ready = st_reg.pkt_ready;
	assign res = st_reg.res;

	a_disabled_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_decide && !st_reg.ctl_en) |=> (res.valid && res.mask == 3'h0))
		else $error("Disabled engine forwarded a packet");

	a_result_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
		res.valid |=> !res.valid ##1 pkt_ready || st_reg.cmd_pend || st_reg.fsm != alf_idle)
		else $error("Result valid longer than one cycle");

	a_error_host: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_decide && st_reg.ctl_en && !st_reg.pkt.directed &&
		(st_reg.pkt.err || st_reg.pkt.ctl) && !st_reg.pkt.abort) |=> res.mask == 3'h1)
		else $error("Error frame not sent to host only");

	a_error_nolearn: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_decide && (st_reg.pkt.err || st_reg.pkt.ctl)) |=>
		st_reg.fsm == alf_idle)
		else $error("Learning on error or control frame");

	a_bypass_host: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_decide && st_reg.ctl_en && st_reg.ctl_bypass &&
		st_reg.pkt.rx_port != 2'h0 && !st_reg.pkt.err && !st_reg.pkt.ctl) |=>
		res.mask == 3'h1)
		else $error("Bypass packet not sent to host only");

	a_directed_mask: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_idle && !st_reg.cmd_pend && pkt_valid && pkt_ready && st_reg.ctl_en &&
		pkt.directed && pkt.rx_port == 2'h0) |=> ##1 (res.valid &&
		res.mask == ($past(pkt.dir_mask, 2) & 3'h6)))
		else $error("Directed packet mask wrong");

	a_learn_entry: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_learn && !st_reg.src_hit) |-> (tbl_we && tbl_wdata[63:62] == 2'h3 &&
		!tbl_wdata[65] && !tbl_wdata[64] && !tbl_wdata[40] && tbl_wdata[61:60] == 2'h1))
		else $error("Learned entry fields wrong");

	a_same_addr_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_decide && st_reg.ctl_en && !st_reg.pkt.directed &&
		!st_reg.pkt.err && !st_reg.pkt.ctl && !st_reg.ctl_bypass &&
		st_reg.pkt.src == st_reg.pkt.dst && st_reg.src_hit) |=>
		(res.mask == 3'h0 && st_reg.fsm == alf_learn))
		else $error("Same address packet not dropped and relearned");

	a_cmd_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_idle && st_reg.cmd_pend && !st_reg.cmd_wr && !st_reg.wr_pend) |=>
		(st_reg.words == $past(cmd_ent) && !st_reg.cmd_pend))
		else $error("Read command did not load data words");

	a_cmd_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_idle && st_reg.cmd_pend && st_reg.cmd_wr) |->
		(tbl_we && tbl_waddr == st_reg.cmd_idx && tbl_wdata == st_reg.words))
		else $error("Write command did not store data words");

	a_scan_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_scan || st_reg.fsm == alf_decide) |-> !tbl_we)
		else $error("Table written during lookup");

	a_init_busy: assert property (@(posedge clk_sys) disable iff (!rst_b)
		st_reg.fsm == alf_clear |-> (!pkt_ready && tbl_we && tbl_wdata[61:60] == 2'h0))
		else $error("Table clear not free or accepting packets");

	a_src_unicast: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_idle && !st_reg.cmd_pend && pkt_valid && pkt_ready) |=>
		!st_reg.pkt.src[40])
		else $error("Source group bit kept after capture");

	a_learn_update: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st_reg.fsm == alf_learn && st_reg.src_hit) |->
		(tbl_we && tbl_waddr == st_reg.src_idx &&
		tbl_wdata[67:66] == st_reg.pkt.rx_port))
		else $error("Known source not updated in place");

endmodule : alf_lookup

// ### bench/alf_far_end.sv
`timescale 1ns/100ps

module alf_far_end
	import alf_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Lookup handshake
	input wire logic pkt_ready,
	input wire alf_res_t res,
	output logic pkt_valid,
	output alf_pkt_t pkt
);
	initial
	begin
		pkt_valid = 1'b0;
		pkt = '0;
	end

	// Offer one packet, hold it until taken, then wait for its mask
	task automatic send(input alf_pkt_t p, output logic [2:0] m);
		int n;
		pkt_valid <= 1'b1;
		pkt <= p;
		do @(posedge clk_sys); while (pkt_ready !== 1'b1);
		pkt_valid <= 1'b0;
		// Released lines carry garbage, not the last packet
		pkt <= ~p;
		n = 0;
		m = 3'bxxx;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (res.valid !== 1'b1 && n < 1100);
		if (res.valid === 1'b1)
			m = res.mask;
	endtask : send
endmodule : alf_far_end

// ### bench/tb.sv
`timescale 1ns/100ps
`include "alf_params.svh"

module tb
	import alf_pkg::*;
;
	logic clk_sys;
	logic rst_b;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic pkt_valid;
	alf_pkt_t pkt;
	logic pkt_ready;
	alf_res_t res;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [71:0] ent;
	logic [31:0] rd;
	logic [47:0] addr_a = 48'h0a11_2233_4401;
	logic [47:0] addr_u = 48'h0a55_6677_8801;
	logic [47:0] addr_b = 48'h0a99_0000_0002;
	logic [47:0] addr_c = 48'h0acc_0000_0003;
	logic [47:0] addr_e = 48'h0ee0_0000_0005;
	logic [47:0] mc = 48'h0100_5e00_0001;
	logic [47:0] bcast = 48'hffff_ffff_ffff;
	logic [71:0] mc_ent = {6'h06, 4'h3, 2'h1, 12'h000, 48'h0100_5e00_0001};
	logic [71:0] bc_ent = {6'h07, 4'hb, 2'h1, 12'h000, 48'hffff_ffff_ffff};
	logic [71:0] su_ent = {4'h0, 2'h2, 4'hf, 2'h3, 12'h000, 48'h0a55_6677_8801};
	logic [71:0] oui_ent = {8'h00, 2'h2, 2'h1, 12'h000, 24'h0ee0_00, 24'h00_0000};

	alf_lookup DUT (
		.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pkt_valid(pkt_valid),
		.pkt(pkt), .pkt_ready(pkt_ready), .res(res)
	);

	alf_far_end far (
		.clk_sys(clk_sys), .pkt_ready(pkt_ready), .res(res), .pkt_valid(pkt_valid), .pkt(pkt)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			miscompares++;
			conclude();
		end
	end

	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0000_00, a};
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
		chk({71'h0, hresp}, 72'h0);
	endtask : bus

	task automatic wait_cmd();
		do bus(1'b0, `ALF_OFF_STATUS, 32'h0000_0000, rd); while (rd[1] !== 1'b0);
	endtask : wait_cmd

	// Only distinct addresses are ever stored
	task automatic tbl_wr(input logic [9:0] idx, input logic [71:0] e);
		bus(1'b1, `ALF_OFF_WORD0, e[31:0], rd);
		bus(1'b1, `ALF_OFF_WORD1, e[63:32], rd);
		bus(1'b1, `ALF_OFF_WORD2, {24'h0000_00, e[71:64]}, rd);
		bus(1'b1, `ALF_OFF_TBL_CTRL, {1'b1, 21'h00_0000, idx}, rd);
		wait_cmd();
	endtask : tbl_wr

	task automatic tbl_rd(input logic [9:0] idx, output logic [71:0] e);
		bus(1'b1, `ALF_OFF_TBL_CTRL, {22'h00_0000, idx}, rd);
		wait_cmd();
		bus(1'b0, `ALF_OFF_WORD0, 32'h0000_0000, rd);
		e[31:0] = rd;
		bus(1'b0, `ALF_OFF_WORD1, 32'h0000_0000, rd);
		e[63:32] = rd;
		bus(1'b0, `ALF_OFF_WORD2, 32'h0000_0000, rd);
		e[71:64] = rd[7:0];
	endtask : tbl_rd

	// Flags are err, ctl, abort, directed
	task automatic go(input logic [1:0] rp, input logic [47:0] d, input logic [47:0] s,
		input logic [3:0] f, input logic [2:0] dm, input logic [2:0] exp);
		logic [2:0] m;
		far.send('{rp, d, s, 16'h0800, 12'h000, f[3], f[2], f[1], f[0], dm}, m);
		chk({69'h0, m}, {69'h0, exp});
	endtask : go

	initial
	begin
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		bus(1'b0, `ALF_OFF_CONTROL, 32'h0000_0000, rd);
		chk({40'h0, rd}, 72'h0);
		bus(1'b0, 8'h20, 32'h0000_0000, rd);
		chk({40'h0, rd}, 72'h0);
		// Still clearing: busy and initialising set
		bus(1'b0, `ALF_OFF_STATUS, 32'h0000_0000, rd);
		chk({40'h0, rd}, 72'h5);
		do @(posedge clk_sys); while (pkt_ready !== 1'b1);
		tbl_rd(10'h3ff, ent);
		chk(ent, 72'h0);
		tbl_wr(10'h003, mc_ent);
		tbl_rd(10'h003, ent);
		chk(ent, mc_ent);
		bus(1'b1, `ALF_OFF_CONTROL, 32'h0000_0001, rd);
		go(2'd2, addr_u, addr_a, 4'h0, 3'h0, 3'h3);
		tbl_rd(10'h000, ent);
		chk(ent, {4'h0, 2'd2, 4'h3, 2'h1, 12'h000, addr_a});
		go(2'd1, addr_u, addr_b, 4'h8, 3'h0, 3'h1);
		go(2'd1, addr_u, addr_b, 4'ha, 3'h0, 3'h0);
		go(2'd1, addr_u, addr_b, 4'h4, 3'h0, 3'h1);
		tbl_rd(10'h001, ent);
		chk(ent, 72'h0);
		go(2'd1, addr_a, addr_c, 4'h0, 3'h0, 3'h4);
		go(2'd1, addr_a, addr_a | 48'h0100_0000_0000, 4'h0, 3'h0, 3'h0);
		tbl_rd(10'h000, ent);
		chk({70'h0, ent[67:66]}, 72'h1);
		go(2'd1, mc, addr_c, 4'h0, 3'h0, 3'h4);
		bus(1'b1, `ALF_OFF_CONTROL, 32'h0000_0003, rd);
		go(2'd2, mc, addr_c, 4'h0, 3'h0, 3'h1);
		go(2'd0, mc, addr_c, 4'h0, 3'h0, 3'h6);
		go(2'd0, addr_a, addr_c, 4'h1, 3'h4, 3'h4);
		bus(1'b1, `ALF_OFF_CONTROL, 32'h0000_0000, rd);
		go(2'd1, mc, addr_c, 4'h0, 3'h0, 3'h0);
		tbl_wr(10'h004, bc_ent);
		bus(1'b1, `ALF_OFF_CONTROL, 32'h0000_0005, rd);
		bus(1'b0, `ALF_OFF_CONTROL, 32'h0000_0000, rd);
		chk({40'h0, rd}, 72'h5);
		go(2'd1, mc, addr_e, 4'h0, 3'h0, 3'h0);
		go(2'd1, bcast, addr_e, 4'h0, 3'h0, 3'h5);
		go(2'd1, addr_u, addr_e, 4'h0, 3'h0, 3'h0);
		// Supervisory unicast pair entry passes the deny filter
		tbl_wr(10'h006, su_ent);
		go(2'd1, addr_u, addr_b, 4'h0, 3'h0, 3'h4);
		// Known source prefix passes the deny filter
		tbl_wr(10'h008, oui_ent);
		go(2'd1, addr_c, addr_e, 4'h0, 3'h0, 3'h1);
		conclude();
	end
endmodule : tb
